// [src/gdrv_pkg.sv]
`default_nettype none
package gdrv_pkg;
  // device clock
  localparam int CLK_PERIOD_NS  = 4;
  // delay times in ns, plain defaults
  localparam int SLEEP_DELAY_NS = 2000;
  localparam int WAKE_DELAY_NS  = 2000;
  localparam int RST_PULSE_NS   = 800;
  localparam int RETRY_NS       = 4000;
  localparam int GATE_WIN_NS    = 1000;
  // least times round up, the reset window is a longest time and rounds down
  localparam int SLEEP_DELAY_CYC = (SLEEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_DELAY_CYC  = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC   = RST_PULSE_NS / CLK_PERIOD_NS;
  localparam int RETRY_CYC       = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_WIN_CYC    = (GATE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 16;
  // serial frame
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS   = 5;
  localparam int DATA_W     = 11;
  localparam int ADDR_W     = 4;
  localparam int RW_BIT     = 15;
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_STAT1 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT2 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_DRV   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OCP   = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_CSA   = 4'h6;
  localparam logic [ADDR_W-1:0] CTRL_FIRST = 4'h2;
  localparam logic [ADDR_W-1:0] CTRL_LAST  = 4'h6;
  localparam int                CTRL_NUM   = 5;
  localparam logic [DATA_W-1:0] CTRL_RESET = 11'h000;
  // field positions
  localparam int S1_FAULT     = 10;
  localparam int S1_GDF       = 8;
  localparam int S1_OVERHEAT_SHUTDOWN      = 6;
  localparam int S2_OTW       = 7;
  localparam int DRV_GDF_DIS  = 8;
  localparam int DRV_OVERHEAT_WARN_TO_PIN  = 7;
  localparam int DRV_CLR      = 0;
  localparam int OVERCURRENT_MODE_SEL_LSB = 6;
  localparam int CSA_SEN_DIS  = 5;
  typedef enum logic [1:0] {
    OCP_LATCH  = 2'b00,
    OCP_RETRY  = 2'b01,
    OCP_REPORT = 2'b10,
    OCP_OFF    = 2'b11
  } gdrv_overcurrent_mode_sel_t;
  typedef enum logic [4:0] {
    PWR_OPER  = 5'b00001,
    PWR_LOW   = 5'b00010,
    PWR_SHUT  = 5'b00100,
    PWR_SLEEP = 5'b01000,
    PWR_WAKE  = 5'b10000
  } gdrv_pwr_t;
endpackage : gdrv_pkg
`default_nettype wire

// [src/gdrv_spi_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface gdrv_spi_if;
  import gdrv_pkg::*;
  logic              spi_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              frame_err;
  modport ctrl (output spi_en, rd_data, input rd_addr, wr_en, wr_addr, wr_data, frame_err);
  modport link (input spi_en, rd_data, output rd_addr, wr_en, wr_addr, wr_data, frame_err);
endinterface : gdrv_spi_if
`default_nettype wire

// [src/gdrv_spi.sv]
`timescale 1ns/1ps
`default_nettype none
module gdrv_spi import gdrv_pkg::*; (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // serial pins
  input  wire logic sclk,
  input  wire logic chip_select_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  // register side
  gdrv_spi_if.link  bus
);
  logic [2:0]        pin_meta;
  logic [2:0]        pin_sync;
  logic              prev_sclk;
  logic              prev_cs;
  logic [4:0]        bit_cnt;
  logic [4:0]        next_bit_cnt;
  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] next_shift_in;
  logic [DATA_W-1:0] shift_out;
  logic [DATA_W-1:0] next_shift_out;
  logic              next_sdo;
  logic              next_sdo_oe;
  logic              wr_en;
  logic              next_wr_en;
  logic              frame_err;
  logic              next_frame_err;
  logic              s_sclk;
  logic              s_cs;
  logic              s_sdi;

  assign s_sclk = pin_sync[2];
  assign s_cs = pin_sync[1];
  assign s_sdi = pin_sync[0];
  // address bits sit in the low bits once five bits are in
  assign bus.rd_addr = shift_in[ADDR_W-1:0];
  assign bus.wr_en = wr_en;
  assign bus.wr_addr = shift_in[FRAME_BITS-2 -: ADDR_W];
  assign bus.wr_data = shift_in[DATA_W-1:0];
  assign bus.frame_err = frame_err;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_wr_en = 1'b0;
    next_frame_err = 1'b0;
    if (!bus.spi_en) begin
      next_bit_cnt = 5'h00;
      next_sdo = 1'b0;
      next_sdo_oe = 1'b0;
    end else if (!s_cs && prev_cs) begin
      next_bit_cnt = 5'h00;
      next_sdo = 1'b0;
      next_sdo_oe = 1'b1;
    end else if (s_cs && !prev_cs) begin
      next_sdo_oe = 1'b0;
      // last data bit must not linger into the next frame's header
      next_sdo = 1'b0;
      if (bit_cnt == 5'(FRAME_BITS)) begin
        next_wr_en = !shift_in[RW_BIT];
      end else begin
        next_frame_err = 1'b1;
      end
    end else if (!s_cs) begin
      if (!s_sclk && prev_sclk) begin
        next_shift_in = {shift_in[FRAME_BITS-2:0], s_sdi};
        if (bit_cnt != 5'h1f) begin
          next_bit_cnt = bit_cnt + 1'b1;
        end
      end else if (s_sclk && !prev_sclk) begin
        if (bit_cnt == 5'(CMD_BITS)) begin
          // snapshot taken before any write of this frame lands
          next_sdo = bus.rd_data[DATA_W-1];
          next_shift_out = {bus.rd_data[DATA_W-2:0], 1'b0};
        end else if (bit_cnt > 5'(CMD_BITS)) begin
          next_sdo = shift_out[DATA_W-1];
          next_shift_out = {shift_out[DATA_W-2:0], 1'b0};
        end else begin
          next_sdo = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: clock low, select high, so no false edge follows reset
      pin_meta <= 3'h2;
      pin_sync <= 3'h2;
      prev_sclk <= 1'b0;
      prev_cs <= 1'b1;
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
      shift_out <= 11'h000;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      wr_en <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      pin_meta <= {sclk, chip_select_n, sdi};
      pin_sync <= pin_meta;
      prev_sclk <= s_sclk;
      prev_cs <= s_cs;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      wr_en <= next_wr_en;
      frame_err <= next_frame_err;
    end
  end
endmodule : gdrv_spi
`default_nettype wire

// [src/gdrv_top.sv]
// Overview of operation
// - retry mode: gates off, alarm, flags latched, all released after retry interval
// - report mode: gates keep running, alarm and flags held until gone and cleared
// - mode 11b or sense disable ignores sense events, separate from other monitors
// - gate not following drive within window: all gates off, alarm, flags latched
// - gate fault restarts after condition gone and clear; disable bit suppresses it
// - overheat warning flag follows temperature; drives alarm only if enabled
// - overheat shutdown: gates and charge pump off, alarm, latched flag until clear
// - enable low: after sleep delay, drivers, pump, regulator and serial port off
// - enable high wakes the device; controller waits wake delay before inputs
// - alarm held low while regulators come up or go down, bounded by delays
// - enable high: operating, pump, regulators and serial on, inputs latched
// - short low pulse on enable clears faults; long low starts shutdown
// - frames are 16 bits: 5 command bits then 11 data bits
// - select high: serial clock and data ignored, data out released
// - data sampled on falling clock edge, changed on rising edge
// - most significant bit first in both directions
// - frame not exactly 16 clocks: frame error, nothing written
// - bit 15 direction, bits 14 to 11 address, bits 10 to 0 data
// - output data is register content as it stood before the frame
// - summary flag is the OR of sense and gate fault flags, live overheat shutdown and routed warning; the alarm pin also goes low during power transitions
`timescale 1ns/1ps
`default_nettype none
module gdrv_top import gdrv_pkg::*; #(
  parameter int SLEEP_CYC = SLEEP_DELAY_CYC,
  parameter int WAKE_CYC  = WAKE_DELAY_CYC,
  parameter int RST_CYC   = RST_PULSE_CYC,
  parameter int RETRY_LEN = RETRY_CYC,
  parameter int GATE_LEN  = GATE_WIN_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // power control
  input  wire logic       enable,
  output logic            charge_pump_en,
  output logic            logic_reg_en,
  // serial port
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  output logic            spi_frame_error,
  // gate command inputs and gate feedback, index 2 is phase a
  input  wire logic [2:0] pwm_hi_in,
  input  wire logic [2:0] pwm_lo_in,
  input  wire logic [2:0] gate_fb_hi,
  input  wire logic [2:0] gate_fb_lo,
  // gate outputs
  output logic [2:0]      high_gate_out,
  output logic [2:0]      low_gate_out,
  // monitors
  input  wire logic [2:0] sense_trip,
  input  wire logic       overheat_warn_in,
  input  wire logic       overheat_shutdown,
  // alarm
  output logic            alarm_out_n
);
  function automatic logic [5:0] interleave(input logic [2:0] hi, input logic [2:0] lo);
    interleave = {hi[2], lo[2], hi[1], lo[1], hi[0], lo[0]};
  endfunction : interleave

  function automatic logic in_ctrl(input logic [ADDR_W-1:0] addr);
    in_ctrl = (addr >= CTRL_FIRST) && (addr <= CTRL_LAST);
  endfunction : in_ctrl

  function automatic logic [2:0] ctrl_idx(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff = addr - CTRL_FIRST;
    ctrl_idx = diff[2:0];
  endfunction : ctrl_idx

  localparam logic [2:0] DRV_IDX = 3'(ADDR_DRV - CTRL_FIRST);
  localparam logic [2:0] OCP_IDX = 3'(ADDR_OCP - CTRL_FIRST);
  localparam logic [2:0] CSA_IDX = 3'(ADDR_CSA - CTRL_FIRST);

  gdrv_spi_if bus ();

  gdrv_spi u_spi (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .sdi           (sdi),
    .sdo           (sdo),
    .sdo_oe        (sdo_oe),
    .bus           (bus.link)
  );

  // pin synchronisers; every monitor and command pin is asynchronous
  logic [17:0] pin_meta;
  logic [17:0] pin_sync;
  logic        en_s;
  logic        otw_s;
  logic        overheat_shutdown_s;
  logic [2:0]  sense_s;
  logic [5:0]  fb_s;
  logic [5:0]  cmd_s;

  assign en_s = pin_sync[17];
  assign otw_s = pin_sync[16];
  assign overheat_shutdown_s = pin_sync[15];
  assign sense_s = pin_sync[14:12];
  assign fb_s = pin_sync[11:6];
  assign cmd_s = pin_sync[5:0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // enable idles high; a low reset value would start a shutdown at release
      pin_meta <= 18'h20000;
      pin_sync <= 18'h20000;
    end else begin
      pin_meta <= {enable, overheat_warn_in, overheat_shutdown, sense_trip,
                   interleave(gate_fb_hi, gate_fb_lo), interleave(pwm_hi_in, pwm_lo_in)};
      pin_sync <= pin_meta;
    end
  end

  // power sequencing
  gdrv_pwr_t        state;
  gdrv_pwr_t        next_state;
  logic [CNT_W-1:0] pwr_cnt;
  logic [CNT_W-1:0] next_pwr_cnt;
  logic             rst_pulse;
  logic             next_rst_pulse;
  logic             awake;
  logic             operating;
  logic             power_trans;

  assign awake = (state != PWR_SLEEP);
  assign operating = (state == PWR_OPER) || (state == PWR_LOW);
  assign power_trans = (state == PWR_SHUT) || (state == PWR_WAKE);

  always_comb begin
    next_state = state;
    next_pwr_cnt = pwr_cnt + 1'b1;
    next_rst_pulse = 1'b0;
    unique case (state)
      PWR_OPER: begin
        next_pwr_cnt = '0;
        if (!en_s) begin
          next_state = PWR_LOW;
        end
      end
      PWR_LOW: begin
        if (en_s) begin
          // short low phase: clear faults only, settings and regulators untouched
          next_state = PWR_OPER;
          next_rst_pulse = 1'b1;
          next_pwr_cnt = '0;
        end else if (pwr_cnt == CNT_W'(RST_CYC)) begin
          next_state = PWR_SHUT;
        end
      end
      PWR_SHUT: begin
        // once committed the shutdown runs to sleep even if enable returns
        if (pwr_cnt == CNT_W'(SLEEP_CYC)) begin
          next_state = PWR_SLEEP;
          next_pwr_cnt = '0;
        end
      end
      PWR_SLEEP: begin
        next_pwr_cnt = '0;
        if (en_s) begin
          next_state = PWR_WAKE;
        end
      end
      PWR_WAKE: begin
        if (!en_s) begin
          next_state = PWR_SHUT;
          next_pwr_cnt = '0;
        end else if (pwr_cnt == CNT_W'(WAKE_CYC)) begin
          next_state = PWR_OPER;
          next_pwr_cnt = '0;
        end
      end
      default: begin
        next_state = PWR_WAKE;
        next_pwr_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= PWR_WAKE;
      pwr_cnt <= '0;
      rst_pulse <= 1'b0;
    end else begin
      state <= next_state;
      pwr_cnt <= next_pwr_cnt;
      rst_pulse <= next_rst_pulse;
    end
  end

  // control registers; the clear bit is self clearing and reads as zero
  logic [DATA_W-1:0] ctrl [CTRL_NUM];
  logic [DATA_W-1:0] next_ctrl [CTRL_NUM];
  logic              clr_wr;
  logic              next_clr_wr;
  logic              clear;

  assign clear = clr_wr || rst_pulse;

  always_comb begin
    next_ctrl = ctrl;
    next_clr_wr = 1'b0;
    if (bus.wr_en && in_ctrl(bus.wr_addr)) begin
      next_ctrl[ctrl_idx(bus.wr_addr)] = bus.wr_data;
      if (bus.wr_addr == ADDR_DRV) begin
        next_clr_wr = bus.wr_data[DRV_CLR];
        next_ctrl[DRV_IDX][DRV_CLR] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CTRL_NUM; i++) begin
        ctrl[i] <= CTRL_RESET;
      end
      clr_wr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      clr_wr <= next_clr_wr;
    end
  end

  // protection and gate drive
  gdrv_overcurrent_mode_sel_t   mode;
  logic             sense_on;
  logic             gdf_dis;
  logic             overheat_warn_to_pin;
  logic [2:0]       sense_flag;
  logic [2:0]       next_sense_flag;
  logic [CNT_W-1:0] retry_cnt;
  logic [CNT_W-1:0] next_retry_cnt;
  logic [CNT_W-1:0] win_cnt [6];
  logic [CNT_W-1:0] next_win_cnt [6];
  logic [5:0]       vgs_flag;
  logic [5:0]       next_vgs_flag;
  logic             gdf_flag;
  logic             next_gdf_flag;
  logic             overheat_shutdown_flag;
  logic             next_overheat_shutdown_flag;
  logic [5:0]       cmd_latch;
  logic [5:0]       next_cmd_latch;
  logic [5:0]       gate;
  logic [5:0]       next_gate;
  logic             summary;
  logic             next_summary;
  logic             next_alarm_n;
  logic             next_pump;
  logic             next_frame_error;
  logic [5:0]       mism;
  logic [5:0]       hit;
  logic             sense_shut;
  logic             drive_ok;
  logic             fault_sum;

  assign mode = gdrv_overcurrent_mode_sel_t'(ctrl[OCP_IDX][OVERCURRENT_MODE_SEL_LSB +: 2]);
  assign sense_on = (mode != OCP_OFF) && !ctrl[CSA_IDX][CSA_SEN_DIS];
  assign gdf_dis = ctrl[DRV_IDX][DRV_GDF_DIS];
  assign overheat_warn_to_pin = ctrl[DRV_IDX][DRV_OVERHEAT_WARN_TO_PIN];
  assign high_gate_out = {gate[5], gate[3], gate[1]};
  assign low_gate_out = {gate[4], gate[2], gate[0]};
  assign bus.spi_en = awake;

  always_comb begin
    next_sense_flag = sense_flag;
    next_retry_cnt = '0;
    if (|sense_flag) begin
      if (mode == OCP_RETRY) begin
        next_retry_cnt = retry_cnt + 1'b1;
        if (retry_cnt == CNT_W'(RETRY_LEN)) begin
          next_sense_flag = 3'h0;
          next_retry_cnt = '0;
        end
      end else if (clear && !(|sense_s)) begin
        next_sense_flag = 3'h0;
      end
    end
    // a trip still present after expiry starts a fresh retry
    if (sense_on && operating) begin
      next_sense_flag = next_sense_flag | sense_s;
    end
    sense_shut = (|sense_flag) && ((mode == OCP_LATCH) || (mode == OCP_RETRY));

    for (int i = 0; i < 6; i++) begin
      mism[i] = awake && (gate[i] != fb_s[i]);
      hit[i] = (win_cnt[i] == CNT_W'(GATE_LEN));
      if (!mism[i]) begin
        next_win_cnt[i] = '0;
      end else if (hit[i]) begin
        next_win_cnt[i] = win_cnt[i];
      end else begin
        next_win_cnt[i] = win_cnt[i] + 1'b1;
      end
    end
    next_vgs_flag = vgs_flag;
    next_gdf_flag = gdf_flag;
    if (clear && !(|mism)) begin
      next_vgs_flag = 6'h00;
      next_gdf_flag = 1'b0;
    end
    if (!gdf_dis) begin
      next_vgs_flag = next_vgs_flag | hit;
      next_gdf_flag = next_gdf_flag || (|hit);
    end

    next_overheat_shutdown_flag = overheat_shutdown_flag;
    if (clear && !overheat_shutdown_s) begin
      next_overheat_shutdown_flag = 1'b0;
    end
    next_overheat_shutdown_flag = next_overheat_shutdown_flag || overheat_shutdown_s;

    drive_ok = operating && !sense_shut && !gdf_flag && !overheat_shutdown_s;
    next_cmd_latch = operating ? cmd_s : cmd_latch;
    next_gate = drive_ok ? cmd_latch : 6'h00;
    next_pump = awake && !overheat_shutdown_s;

    // the pin and the summary bit share one fault term; only the pin also goes low during power transitions
    fault_sum = (|sense_flag) || gdf_flag || overheat_shutdown_s || (otw_s && overheat_warn_to_pin);
    next_summary = fault_sum;
    next_alarm_n = !(fault_sum || power_trans);
    next_frame_error = (spi_frame_error && !clear) || bus.frame_err;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sense_flag <= 3'h0;
      retry_cnt <= '0;
      for (int i = 0; i < 6; i++) begin
        win_cnt[i] <= '0;
      end
      vgs_flag <= 6'h00;
      gdf_flag <= 1'b0;
      overheat_shutdown_flag <= 1'b0;
      cmd_latch <= 6'h00;
      gate <= 6'h00;
      summary <= 1'b0;
      alarm_out_n <= 1'b0;
      charge_pump_en <= 1'b0;
      logic_reg_en <= 1'b0;
      spi_frame_error <= 1'b0;
    end else begin
      sense_flag <= next_sense_flag;
      retry_cnt <= next_retry_cnt;
      win_cnt <= next_win_cnt;
      vgs_flag <= next_vgs_flag;
      gdf_flag <= next_gdf_flag;
      overheat_shutdown_flag <= next_overheat_shutdown_flag;
      cmd_latch <= next_cmd_latch;
      gate <= next_gate;
      summary <= next_summary;
      alarm_out_n <= next_alarm_n;
      charge_pump_en <= next_pump;
      logic_reg_en <= awake;
      spi_frame_error <= next_frame_error;
    end
  end

  // register read; unmapped addresses read zero
  always_comb begin
    if (bus.rd_addr == ADDR_STAT1) begin
      bus.rd_data = '0;
      bus.rd_data[S1_FAULT] = summary;
      bus.rd_data[S1_GDF] = gdf_flag;
      bus.rd_data[S1_OVERHEAT_SHUTDOWN] = overheat_shutdown_flag;
    end else if (bus.rd_addr == ADDR_STAT2) begin
      bus.rd_data = {sense_flag, otw_s, 1'b0, vgs_flag};
    end else if (in_ctrl(bus.rd_addr)) begin
      bus.rd_data = ctrl[ctrl_idx(bus.rd_addr)];
    end else begin
      bus.rd_data = '0;
    end
  end
endmodule : gdrv_top
`default_nettype wire

// [test/gdrv_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module gdrv_properties (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // power
  input wire logic       enable,
  input wire logic       charge_pump_en,
  input wire logic       logic_reg_en,
  // serial port
  input wire logic       sclk,
  input wire logic       chip_select_n,
  input wire logic       sdi,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  input wire logic       spi_frame_error,
  // gates
  input wire logic [2:0] pwm_hi_in,
  input wire logic [2:0] pwm_lo_in,
  input wire logic [2:0] gate_fb_hi,
  input wire logic [2:0] gate_fb_lo,
  input wire logic [2:0] high_gate_out,
  input wire logic [2:0] low_gate_out,
  // monitors and alarm
  input wire logic [2:0] sense_trip,
  input wire logic       overheat_warn_in,
  input wire logic       overheat_shutdown,
  input wire logic       alarm_out_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // bounds assume the short counts used in the bench
  sdo_idle_a: assert property (chip_select_n [*4] |-> !sdo_oe)
    else $error("sdo not released");
  hdr_zero_a: assert property ($fell(chip_select_n) |-> !sdo [*8])
    else $error("header bits not zero");
  sleep_off_a: assert property (!logic_reg_en |->
    {charge_pump_en, sdo_oe, high_gate_out, low_gate_out} == 8'h00)
    else $error("sleep left drive on");
  shut_gates_a: assert property (overheat_shutdown [*4] |-> {charge_pump_en, alarm_out_n, high_gate_out} == 5'h00)
    else $error("shutdown not applied");
  wake_alarm_a: assert property ($rose(logic_reg_en) |-> !alarm_out_n [*8])
    else $error("alarm not held at wake");
  sleep_entry_a: assert property ($fell(enable) ##1 !enable [*8] |-> logic_reg_en [*8] ##[1:30] !logic_reg_en)
    else $error("sleep entry timing");
  wake_exit_a: assert property ($rose(enable) && !logic_reg_en |-> ##[1:6] logic_reg_en)
    else $error("no wake from sleep");
  pump_on_a: assert property ((enable && logic_reg_en && !overheat_shutdown) [*6] |-> charge_pump_en)
    else $error("pump off while operating");
  frame_err_a: assert property ($rose(spi_frame_error) |-> chip_select_n && $past(chip_select_n, 2))
    else $error("frame error inside frame");
endmodule : gdrv_properties
bind gdrv_top gdrv_properties chk_u (.*);
`default_nettype wire

// [test/gdrv_spi_master.sv]
`timescale 1ns/1ps
`default_nettype none
module gdrv_spi_master (
  // clock
  input wire logic clk_sys,
  // serial pins
  output var logic sclk,
  output var logic chip_select_n,
  output var logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end
  // half period of 4 device clocks, so the device's 3 clock sync latency still fits
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    repeat (110) @(posedge clk_sys);
    #1 chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys);
      #1 sclk = 1'b1;
      sdi = w[15 - (i % 16)];
      repeat (4) @(posedge clk_sys);
      #1 sclk = 1'b0;
      r = {r[14:0], sdo};
    end
    repeat (4) @(posedge clk_sys);
    #1 chip_select_n = 1'b1;
    // data line toggles after release, which the device must ignore while select is high
    sdi = ~sdi;
  endtask : xfer
endmodule : gdrv_spi_master
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        enable = 1'b1;
  logic        warn = 1'b0;
  logic        ots = 1'b0;
  logic [2:0]  hi = 3'h5;
  logic [2:0]  trip = 3'h0;
  logic [2:0]  brk = 3'h0;
  logic [31:0] rnd = 32'h62fa;
  logic [10:0] q;
  logic [15:0] r;
  logic        sclk, chip_select_n, sdi, sdo, sdo_oe, spi_frame_error;
  logic        charge_pump_en, logic_reg_en, alarm_out_n;
  logic [2:0]  high_gate_out, low_gate_out;
  int          mdl [16];
  int          n_errors = 0;
  int          n_checks = 0;

  always #2 clk_sys = ~clk_sys;

  gdrv_top #(.SLEEP_CYC(40), .WAKE_CYC(20), .RST_CYC(10), .RETRY_LEN(30), .GATE_LEN(8)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .enable(enable), .charge_pump_en(charge_pump_en),
    .logic_reg_en(logic_reg_en), .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .spi_frame_error(spi_frame_error), .pwm_hi_in(hi),
    .pwm_lo_in(~hi), .gate_fb_hi(high_gate_out ^ brk), .gate_fb_lo(low_gate_out),
    .high_gate_out(high_gate_out), .low_gate_out(low_gate_out), .sense_trip(trip),
    .overheat_warn_in(warn), .overheat_shutdown(ots), .alarm_out_n(alarm_out_n));

  gdrv_spi_master m_u (.clk_sys(clk_sys), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdi(sdi), .sdo(sdo));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // status words are not modelled here, callers compare them
  task automatic acc(input logic rw, input logic [3:0] a, input logic [10:0] d);
    m_u.xfer({rw, a, d}, 16, r);
    q = r[10:0];
    if (a > 4'h1) chk(16'(q), 16'(mdl[a]));
    if (!rw && a > 4'h1 && a < 4'h7) mdl[a] = int'(d & (a == 4'h2 ? 11'h7fe : 11'h7ff));
  endtask : acc

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end

  initial begin
    wt(3);
    rst_n = 1'b1;
    wt(40);
    chk(16'(alarm_out_n), 16'h1);
    for (int a = 0; a < 8; a++) begin
      rnd = lfsr(rnd);
      acc(1'b0, 4'(a), rnd[10:0]);
    end
    for (int a = 0; a < 8; a++) begin
      acc(1'b1, 4'(a), 11'h000);
      if (a < 2) chk(16'(q), 16'h0);
    end
    for (int n = 15; n < 18; n += 2) begin
      m_u.xfer({1'b0, 4'h5, 11'h555}, n, r);
      wt(6);
      chk(16'(spi_frame_error), 16'h1);
      acc(1'b1, 4'h5, 11'h000);
      acc(1'b0, 4'h2, 11'h001);
      wt(6);
      chk(16'(spi_frame_error), 16'h0);
    end
    // modes 00..11, then latch mode with the sense disable set
    for (int m = 0; m < 5; m++) begin
      acc(1'b0, 4'h5, 11'(mdl[5]) & 11'h73f | 11'(m % 4) << 6);
      acc(1'b0, 4'h6, 11'(m == 4) << 5);
      wt(4);
      rnd = lfsr(rnd);
      hi = rnd[2:0];
      trip = 3'h4;
      wt(6);
      chk({12'h0, alarm_out_n, high_gate_out}, {12'h0, m > 2, m < 2 ? 3'h0 : hi});
      trip = 3'h0;
      wt(40);
      chk(16'(alarm_out_n), 16'(m == 1 || m > 2));
      acc(1'b1, 4'h1, 11'h000);
      chk(16'(q[10]), 16'(m == 0 || m == 2));
      acc(1'b0, 4'h2, 11'h001);
      wt(8);
      chk(16'(alarm_out_n), 16'h1);
    end
    brk = 3'h4;
    wt(16);
    chk({9'h0, alarm_out_n, high_gate_out, low_gate_out}, 16'h0);
    acc(1'b1, 4'h1, 11'h000);
    chk(16'(q[5:0]), 16'h20);
    brk = 3'h0;
    enable = 1'b0;
    wt(5);
    enable = 1'b1;
    wt(10);
    chk({8'h0, logic_reg_en, alarm_out_n, high_gate_out, low_gate_out}, {10'h3, hi, ~hi});
    acc(1'b1, 4'h5, 11'h000);
    acc(1'b0, 4'h2, 11'h100);
    brk = 3'h2;
    wt(16);
    chk(16'(alarm_out_n), 16'h1);
    brk = 3'h0;
    for (int p = 0; p < 2; p++) begin
      acc(1'b0, 4'h2, 11'(p) << 7);
      warn = 1'b1;
      wt(5);
      chk(16'(alarm_out_n), 16'(p == 0));
      acc(1'b1, 4'h1, 11'h000);
      chk(16'(q[7]), 16'h1);
      warn = 1'b0;
      wt(5);
      chk(16'(alarm_out_n), 16'h1);
    end
    ots = 1'b1;
    wt(5);
    chk({11'h0, charge_pump_en, alarm_out_n, high_gate_out}, 16'h0);
    ots = 1'b0;
    wt(6);
    chk({14'h0, charge_pump_en, alarm_out_n}, 16'h3);
    acc(1'b1, 4'h0, 11'h000);
    chk(16'(q), 16'h40);
    acc(1'b0, 4'h2, 11'h001);
    acc(1'b1, 4'h0, 11'h000);
    chk(16'(q), 16'h0);
    enable = 1'b0;
    wt(60);
    chk({13'h0, logic_reg_en, charge_pump_en, alarm_out_n}, 16'h1);
    enable = 1'b1;
    wt(4);
    chk(16'(alarm_out_n), 16'h0);
    wt(40);
    chk(16'(alarm_out_n), 16'h1);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
